// [core/ssr_cfg.svh]
// Constants for the serial slave read responder: function codes, map, timing.
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

`define SSR_FC_DISCRETE      8'h02
`define SSR_FC_HOLDING       8'h03
`define SSR_FC_INPUT         8'h04
`define SSR_FC_EXC_FLAG      8'h80
`define SSR_EXC_ILL_FUNC     8'h01
`define SSR_EXC_ILL_ADDR     8'h02
`define SSR_EXC_ILL_VALUE    8'h03

`define SSR_ADDR_MIN         8'h01
`define SSR_ADDR_MAX         8'hf7
`define SSR_ADDR_DEFAULT     8'h01

`define SSR_DISCRETE_COUNT   16'h0015
`define SSR_TEMP_ADDR        16'h0008
`define SSR_TEMP_END         16'h000a
`define SSR_RELAY_MAP_ADDR   16'h0073
`define SSR_LOOP_A_SRC_ADDR  16'h0075

`define SSR_QUERY_LEN_RTU    4'h8
`define SSR_QUERY_LEN_ASCII  4'h7
`define SSR_CRC_INIT         16'hffff
`define SSR_CRC_POLY         16'ha001

// Silent interval: 3.5 characters of 11 bits at the default 9600 baud.
`define SSR_CLK_HZ           64'd20000000
`define SSR_BAUD             64'd9600
`define SSR_CHAR_BITS        64'd11
`define SSR_IDLE_CHAR_X10    64'd35
`define SSR_IDLE_CYCLES \
	((`SSR_IDLE_CHAR_X10 * `SSR_CHAR_BITS * `SSR_CLK_HZ + `SSR_BAUD * 64'd10 - 64'd1) \
	/ (`SSR_BAUD * 64'd10))

`endif

// [core/ssr_pkg.sv]
// Types shared by the serial slave read responder.
package ssr_pkg;
	typedef enum logic [4:0] {
		SSR_IDLE  = 5'b00001,
		SSR_RECV  = 5'b00010,
		SSR_CHECK = 5'b00100,
		SSR_GAP   = 5'b01000,
		SSR_SEND  = 5'b10000
	} ssr_state_t;

	typedef logic [7:0] ssr_byte_t;
endpackage : ssr_pkg

// [core/ssr_check.sv]
// Running error check: CRC-16 for binary framing and LRC for text framing.
`timescale 1ns/1ps
`include "ssr_cfg.svh"

module ssr_check
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            clear,
	input  wire logic            feed,
	input  wire ssr_pkg::ssr_byte_t data,
	output logic [15:0]          crc,
	output logic [7:0]           sum
);
	import ssr_pkg::*;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ `SSR_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			crc <= `SSR_CRC_INIT;
			sum <= 8'h00;
		end
		else if (clear)
		begin
			crc <= `SSR_CRC_INIT;
			sum <= 8'h00;
		end
		else if (feed)
		begin
			crc <= crc_step(crc, data);
			sum <= sum + data;
		end
	end
endmodule : ssr_check

// [core/ssr_gap_timer.sv]
// Counts the silent interval held on the line before a response.
`timescale 1ns/1ps
`include "ssr_cfg.svh"

module ssr_gap_timer
#(
	parameter logic [23:0] CYCLES = 24'(`SSR_IDLE_CYCLES)
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      done
);
	logic [23:0] count_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= 24'h000000;
			done    <= 1'b0;
		end
		else if (start)
		begin
			count_q <= CYCLES;
			done    <= 1'b0;
		end
		else if (count_q > 24'h000001)
		begin
			count_q <= count_q - 24'h000001;
		end
		else if (count_q == 24'h000001)
		begin
			count_q <= 24'h000000;
			done    <= 1'b1;
		end
	end
endmodule : ssr_gap_timer

// [core/ssr_top.sv]
// Slave read responder: takes framed query bytes, answers reads of the point map.
//
// Overview of operation
// R1: A query is address, function, start high/low, count high/low, check; 02/03/04 pick the table.
// R2: Discrete data carry one bit per input, the start address in bit 0 of the first byte, upward.
// R3: A status bit is 1 when its input is active and 0 when it is not.
// R4: Unused high bits of the last discrete byte are sent as zero.
// R5: A response echoes address and function, gives the data byte count, then data and check.
// R6: Twenty-one discrete inputs sit at addresses equal to input number less one.
// R7: Registers go out as two bytes each, high byte first, multi-register values high word first.
// R8: Temperature is a 32-bit float in input registers 08 and 09 hex.
// R9: The master reads two points from the first register of a float; other reads return raw data.
// R10: Holding register 115 carries the six relay source bits in its low bits.
// R11: Holding register 117 carries the binary loop A source selector.
// R12: Only queries to the configured address, 1 to 247, are answered; address 0 is ignored.
// R13: An unsupported function or object address gets an exception response.
// R14: In binary framing the driver is enabled and the line held idle 3.5 characters before sending.
// R15: A query whose check does not match is dropped without a response.
// R16: The response check is computed over all preceding response bytes in the active framing.
`timescale 1ns/1ps
`include "ssr_cfg.svh"

module ssr_top
#(
	parameter logic [23:0] IDLE_CYCLES = 24'(`SSR_IDLE_CYCLES)
)
(
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic [7:0]         own_address,
	input  wire logic               ascii_mode,
	input  wire logic [20:0]        discrete_inputs,
	input  wire logic [31:0]        temperature_value,
	input  wire logic [5:0]         relay_source_select_bits,
	input  wire logic [15:0]        current_loop_a_source_select,
	input  wire ssr_pkg::ssr_byte_t rx_data,
	input  wire logic               rx_valid,
	input  wire logic               rx_frame_end,
	input  wire logic               tx_ready,
	output ssr_pkg::ssr_byte_t      tx_data,
	output logic                    tx_valid,
	output logic                    tx_line_enable,
	output logic                    query_dropped
);
	import ssr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers.

	function automatic logic [15:0] reg_word(input logic [7:0] fc, input logic [15:0] addr);
		logic [15:0] w;
		w = 16'h0000;
		if (fc == `SSR_FC_INPUT)
		begin
			if (addr == `SSR_TEMP_ADDR)
				w = temperature_value[31:16]; // R8 R7
			else if (addr == `SSR_TEMP_ADDR + 16'h0001)
				w = temperature_value[15:0]; // R8
		end
		else if (addr == `SSR_RELAY_MAP_ADDR)
			w = {10'h000, relay_source_select_bits}; // R10
		else if (addr == `SSR_LOOP_A_SRC_ADDR)
			w = current_loop_a_source_select; // R11
		return w;
	endfunction : reg_word

	function automatic logic [7:0] disc_byte(input logic [15:0] start, input logic [15:0] count,
		input logic [7:0] k);
		logic [7:0]  b;
		logic [15:0] pos;
		b = 8'h00;
		for (int j = 0; j < 8; j++)
		begin
			pos = {5'h00, k, 3'(j)};
			if (pos < count && start + pos < `SSR_DISCRETE_COUNT)
				b[j] = discrete_inputs[5'(start + pos)]; // R2 R3 R6
			// Bits past the requested count stay zero.  R4
		end
		return b;
	endfunction : disc_byte

	////////////////////////////////////////////////////////////////////////////////
	// State and query capture.

	ssr_state_t  state_q;
	logic [3:0]  rx_cnt_q;
	logic        rx_over_q;
	logic [7:0]  q_addr_q;
	logic [7:0]  q_fc_q;
	logic [15:0] q_start_q;
	logic [15:0] q_count_q;
	logic [7:0]  rsp_fc_q;
	logic [7:0]  rsp_code_q;
	logic [7:0]  data_len_q;
	logic [7:0]  tx_idx_q;
	logic [15:0] crc;
	logic [7:0]  sum;
	logic        gap_done;
	logic        chk_clear;
	logic        chk_feed;
	ssr_byte_t   chk_data;
	ssr_byte_t   next_byte;
	logic [7:0]  last_idx;
	logic [3:0]  query_len;
	logic        accept;
	logic        addr_ok;
	logic        check_ok;
	logic        len_ok;

	assign query_len = ascii_mode ? `SSR_QUERY_LEN_ASCII : `SSR_QUERY_LEN_RTU; // R1
	assign addr_ok   = q_addr_q == own_address && own_address >= `SSR_ADDR_MIN
		&& own_address <= `SSR_ADDR_MAX; // R12
	// Feeding the received check into the running check leaves zero when it matches.
	assign check_ok  = ascii_mode ? (sum == 8'h00) : (crc == 16'h0000); // R15
	assign len_ok    = rx_cnt_q == query_len && !rx_over_q;
	assign accept    = tx_valid && tx_ready;
	// Binary framing ends with two check bytes, text framing with one.
	assign last_idx  = 8'd4 + data_len_q - (ascii_mode ? 8'd1 : 8'd0);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_cnt_q  <= 4'h0;
			rx_over_q <= 1'b0;
			q_addr_q  <= 8'h00;
			q_fc_q    <= 8'h00;
			q_start_q <= 16'h0000;
			q_count_q <= 16'h0000;
		end
		else if (state_q == SSR_IDLE)
		begin
			rx_cnt_q  <= 4'h0;
			rx_over_q <= 1'b0;
			if (rx_valid)
			begin
				q_addr_q <= rx_data;
				rx_cnt_q <= 4'h1;
			end
		end
		else if (state_q == SSR_RECV && rx_valid)
		begin
			if (rx_cnt_q == query_len)
				rx_over_q <= 1'b1;
			else
				rx_cnt_q <= rx_cnt_q + 4'h1;
			unique case (rx_cnt_q)
				4'h1: q_fc_q           <= rx_data; // R1
				4'h2: q_start_q[15:8]  <= rx_data;
				4'h3: q_start_q[7:0]   <= rx_data;
				4'h4: q_count_q[15:8]  <= rx_data;
				4'h5: q_count_q[7:0]   <= rx_data;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Query validation: choose data or exception answer.

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_fc_q   <= 8'h00;
			rsp_code_q <= 8'h00;
			data_len_q <= 8'h00;
		end
		else if (state_q == SSR_CHECK)
		begin
			rsp_fc_q   <= q_fc_q; // R5
			data_len_q <= 8'h00;
			rsp_code_q <= 8'h00;
			if (q_fc_q != `SSR_FC_DISCRETE && q_fc_q != `SSR_FC_HOLDING
				&& q_fc_q != `SSR_FC_INPUT)
			begin
				rsp_fc_q   <= q_fc_q | `SSR_FC_EXC_FLAG; // R13
				rsp_code_q <= `SSR_EXC_ILL_FUNC;
			end
			else if (q_count_q == 16'h0000)
			begin
				rsp_fc_q   <= q_fc_q | `SSR_FC_EXC_FLAG;
				rsp_code_q <= `SSR_EXC_ILL_VALUE;
			end
			else if (q_fc_q == `SSR_FC_DISCRETE
				&& {1'b0, q_start_q} + {1'b0, q_count_q} <= {1'b0, `SSR_DISCRETE_COUNT})
			begin
				data_len_q <= 8'((q_count_q + 16'h0007) >> 3); // R2 R5
				rsp_code_q <= 8'((q_count_q + 16'h0007) >> 3);
			end
			// A float read that starts mid-value is served as raw words.  R9
			else if (q_fc_q == `SSR_FC_INPUT && q_start_q >= `SSR_TEMP_ADDR
				&& {1'b0, q_start_q} + {1'b0, q_count_q} <= {1'b0, `SSR_TEMP_END})
			begin
				data_len_q <= 8'(q_count_q << 1); // R7
				rsp_code_q <= 8'(q_count_q << 1);
			end
			else if (q_fc_q == `SSR_FC_HOLDING && q_count_q == 16'h0001
				&& (q_start_q == `SSR_RELAY_MAP_ADDR || q_start_q == `SSR_LOOP_A_SRC_ADDR))
			begin
				data_len_q <= 8'h02; // R7
				rsp_code_q <= 8'h02;
			end
			else
			begin
				rsp_fc_q   <= q_fc_q | `SSR_FC_EXC_FLAG; // R13
				rsp_code_q <= `SSR_EXC_ILL_ADDR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Response byte selection.

	always_comb
	begin
		logic [7:0]  k;
		logic [15:0] w;
		k = tx_idx_q - 8'd3;
		w = reg_word(q_fc_q, q_start_q + {9'h000, k[7:1]});
		if (tx_idx_q == 8'd0)
			next_byte = q_addr_q; // R5
		else if (tx_idx_q == 8'd1)
			next_byte = rsp_fc_q;
		else if (tx_idx_q == 8'd2)
			next_byte = rsp_code_q;
		else if (tx_idx_q < 8'd3 + data_len_q)
		begin
			if (q_fc_q == `SSR_FC_DISCRETE)
				next_byte = disc_byte(q_start_q, q_count_q, k); // R2
			else
				next_byte = k[0] ? w[7:0] : w[15:8]; // R7
		end
		else if (ascii_mode)
			next_byte = 8'(8'h00 - sum); // R16
		else if (tx_idx_q == 8'd3 + data_len_q)
			next_byte = crc[7:0]; // R16
		else
			next_byte = crc[15:8];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= SSR_IDLE;
		end
		else
		begin
			unique case (state_q)
				SSR_IDLE:
					if (rx_valid)
						state_q <= SSR_RECV;
				SSR_RECV:
					if (rx_frame_end)
						state_q <= (len_ok && check_ok && addr_ok) ? SSR_CHECK : SSR_IDLE; // R15 R12
				SSR_CHECK:
					state_q <= SSR_GAP;
				SSR_GAP:
					if (gap_done || ascii_mode)
						state_q <= SSR_SEND; // R14
				SSR_SEND:
					if (accept && tx_idx_q == last_idx + 8'd1)
						state_q <= SSR_IDLE;
				default:
					state_q <= SSR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			query_dropped <= 1'b0;
		else
			query_dropped <= state_q == SSR_RECV && rx_frame_end
				&& !(len_ok && check_ok) && addr_ok; // R15
	end

	// The driver stays enabled from the silent interval to the last byte so the line never floats.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_line_enable <= 1'b0;
		else
			tx_line_enable <= state_q == SSR_CHECK || state_q == SSR_GAP
				|| (state_q == SSR_SEND && !(accept && tx_idx_q == last_idx + 8'd1)); // R14
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_idx_q <= 8'h00;
			tx_data  <= 8'h00;
			tx_valid <= 1'b0;
		end
		else if (state_q != SSR_SEND)
		begin
			tx_idx_q <= 8'h00;
			tx_valid <= 1'b0;
		end
		else if (!tx_valid || accept)
		begin
			// Each header and data byte enters the check as it is loaded, so the check bytes cover every byte before the first of them.
			if (tx_idx_q <= last_idx)
			begin
				tx_data  <= next_byte;
				tx_valid <= 1'b1;
				tx_idx_q <= tx_idx_q + 8'd1;
			end
			else
			begin
				tx_valid <= 1'b0;
				tx_idx_q <= tx_idx_q + 8'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error check and silent-interval timer.

	// The same check unit serves the query and then the answer; they never overlap.
	assign chk_clear = state_q == SSR_IDLE || state_q == SSR_CHECK;
	assign chk_feed  = (rx_valid && state_q != SSR_SEND && state_q != SSR_GAP
		&& state_q != SSR_CHECK && rx_cnt_q < query_len)
		|| (state_q == SSR_SEND && (!tx_valid || accept) && tx_idx_q < 8'd3 + data_len_q); // R16
	assign chk_data  = state_q == SSR_SEND ? next_byte : rx_data;

	ssr_check u_check
	(
		.clk   (clk),
		.rst_n (rst_n),
		.clear (chk_clear && !(state_q == SSR_IDLE && rx_valid)),
		.feed  (chk_feed),
		.data  (chk_data),
		.crc   (crc),
		.sum   (sum)
	);

	ssr_gap_timer
	#(
		.CYCLES (IDLE_CYCLES)
	)
	u_gap
	(
		.clk   (clk),
		.rst_n (rst_n),
		.start (state_q == SSR_CHECK && !ascii_mode), // R14
		.done  (gap_done)
	);
endmodule : ssr_top

// [tb/ssr_top_sva.sv]
// Port checker for the read responder, bound into its top module.
`timescale 1ns/1ps
module ssr_chk
#(
	parameter logic [23:0] IDLE_CYCLES = 24'h8
)
(
	input wire logic               clk,
	input wire logic               nrst,
	input wire logic [7:0]         own_address,
	input wire logic               ascii_mode,
	input wire logic [20:0]        discrete_inputs,
	input wire logic [31:0]        temperature_value,
	input wire logic [5:0]         relay_source_select_bits,
	input wire logic [15:0]        current_loop_a_source_select,
	input wire ssr_pkg::ssr_byte_t rx_data,
	input wire logic               rx_valid,
	input wire logic               rx_frame_end,
	input wire logic               tx_ready,
	input wire ssr_pkg::ssr_byte_t tx_data,
	input wire logic               tx_valid,
	input wire logic               tx_line_enable,
	input wire logic               query_dropped
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// The gap length is written for the simulated IDLE_CYCLES of 8 only.
	sequence s_gap;
		!tx_valid [*8];
	endsequence
	sequence s_release;
		!tx_valid ##1 !tx_line_enable;
	endsequence
	a_byte_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("response byte changed before it was taken");
	a_drive_first: assert property (tx_valid |-> tx_line_enable)
		else $error("byte offered while the line driver is off");
	a_idle_gap: assert property ($rose(tx_line_enable) && !ascii_mode |-> s_gap ##[1:8] tx_valid)
		else $error("silent gap before the response is wrong");
	a_echo_addr: assert property ($rose(tx_valid) |-> tx_data == own_address)
		else $error("response does not start with the own address");
	a_end_release: assert property ($fell(tx_valid) |-> s_release)
		else $error("line driver kept on after the response");
	a_drop_pulse: assert property (query_dropped |=> !query_dropped)
		else $error("drop flag longer than one cycle");
	a_drop_quiet: assert property (query_dropped |-> s_gap)
		else $error("response sent for a dropped query");
	a_bad_own: assert property (own_address == 8'h00 || own_address > 8'hf7 |-> !tx_line_enable)
		else $error("answered with an illegal own address");
endmodule : ssr_chk

bind ssr_top ssr_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (.clk(clk), .nrst(nrst),
	.own_address(own_address), .ascii_mode(ascii_mode), .discrete_inputs(discrete_inputs),
	.temperature_value(temperature_value), .relay_source_select_bits(relay_source_select_bits),
	.current_loop_a_source_select(current_loop_a_source_select), .rx_data(rx_data),
	.rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_line_enable(tx_line_enable), .query_dropped(query_dropped));

// [tb/ssr_master.sv]
// Bus master model: sends query bytes, collects response bytes, can stall.
`timescale 1ns/1ps
module ssr_master
(
	input  wire logic       clk,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       slow,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            rx_frame_end,
	output logic            tx_ready
);
	logic [7:0] got[$];
	logic [1:0] ph_q;
	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_frame_end = 1'b0;
		tx_ready = 1'b1;
		ph_q = 2'h0;
	end
	// A slow master takes one byte in four cycles, so the responder must hold its byte.
	always @(posedge clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_data);
		ph_q <= ph_q + 2'h1;
		tx_ready <= !slow || ph_q == 2'h3;
	end
	// Outside a byte the data line shows the inverse of the last byte, never a held copy.
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i])
		begin
			@(posedge clk);
			rx_data <= q[i];
			rx_valid <= 1'b1;
		end
		@(posedge clk);
		rx_data <= ~q[q.size() - 1];
		rx_valid <= 1'b0;
		rx_frame_end <= 1'b1;
		@(posedge clk);
		rx_frame_end <= 1'b0;
	endtask : send
endmodule : ssr_master

// [tb/ssr_tb.sv]
// Self-checking bench for the serial slave read responder.
`timescale 1ns/1ps
module testbench;
	typedef logic [7:0] ssr_bq_t[$];
	localparam logic [7:0] me = 8'h20;
	logic               clk, nrst, ascii_mode, slow;
	logic [7:0]         own_address;
	logic [20:0]        discrete_inputs;
	logic [31:0]        temperature_value;
	logic [5:0]         relay_source_select_bits;
	logic [15:0]        current_loop_a_source_select;
	ssr_pkg::ssr_byte_t rx_data, tx_data;
	logic               rx_valid, rx_frame_end, tx_ready, tx_valid, tx_line_enable;
	logic               query_dropped;
	int                 errors, tests_run, cycles, drops;
	ssr_top #(.IDLE_CYCLES(24'h8)) dut (.clk(clk), .nrst(nrst), .own_address(own_address),
		.ascii_mode(ascii_mode), .discrete_inputs(discrete_inputs),
		.temperature_value(temperature_value), .relay_source_select_bits(relay_source_select_bits),
		.current_loop_a_source_select(current_loop_a_source_select), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_line_enable(tx_line_enable), .query_dropped(query_dropped));
	ssr_master m (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .slow(slow),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));
	////////////////////////////////////////////////////////////////////////////////////////////
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (query_dropped === 1'b1)
			drops <= drops + 1;
		if (cycles == 6000)
		begin
			errors = errors + 1;
			close_out();
		end
	end
	task close_out;
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [15:0] crc16(input ssr_bq_t b);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i])
		begin
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction : crc16
	function automatic logic [7:0] lrc(input ssr_bq_t b);
		logic [7:0] s;
		s = 8'h00;
		foreach (b[i]) s = s + b[i];
		return 8'h00 - s;
	endfunction : lrc
	task do_reset(input logic txt);
		nrst <= 1'b0;
		ascii_mode <= txt;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : do_reset
	// An empty expected reply means the query must go unanswered.
	task automatic xact(input ssr_bq_t q, input ssr_bq_t r, input logic bad);
		logic [15:0] c;
		int          n;
		c = (ascii_mode ? {8'h00, lrc(q)} : crc16(q)) ^ {16{bad}};
		q.push_back(c[7:0]);
		if (!ascii_mode) q.push_back(c[15:8]);
		c = ascii_mode ? {8'h00, lrc(r)} : crc16(r);
		if (r.size() > 0) r.push_back(c[7:0]);
		if (r.size() > 0 && !ascii_mode) r.push_back(c[15:8]);
		m.got.delete();
		m.send(q);
		for (n = 0; n < 100 && !(r.size() > 0 && m.got.size() == r.size() && !tx_line_enable); n++)
			@(negedge clk);
		repeat (2) @(posedge clk);
		chk(16'(m.got.size()), 16'(r.size()));
		foreach (r[i]) if (i < m.got.size()) chk({8'h00, m.got[i]}, {8'h00, r[i]});
	endtask : xact
	task s_discrete;
		discrete_inputs <= 21'h040000;
		xact('{me, 8'h02, 8'h00, 8'h12, 8'h00, 8'h01}, '{me, 8'h02, 8'h01, 8'h01}, 0);
		discrete_inputs <= 21'h15a5c3;
		xact('{me, 8'h02, 8'h00, 8'h00, 8'h00, 8'h15}, '{me, 8'h02, 8'h03, 8'hc3, 8'ha5, 8'h15}, 0);
		xact('{me, 8'h02, 8'h00, 8'h03, 8'h00, 8'h06}, '{me, 8'h02, 8'h01, 8'h38}, 0);
	endtask : s_discrete
	task s_registers;
		xact('{me, 8'h04, 8'h00, 8'h08, 8'h00, 8'h02}, '{me, 8'h04, 8'h04, 8'h42, 8'h90, 8'h99, 8'h9a}, 0);
		xact('{me, 8'h04, 8'h00, 8'h09, 8'h00, 8'h01}, '{me, 8'h04, 8'h02, 8'h99, 8'h9a}, 0);
		xact('{me, 8'h03, 8'h00, 8'h73, 8'h00, 8'h01}, '{me, 8'h03, 8'h02, 8'h00, 8'h16}, 0);
		xact('{me, 8'h03, 8'h00, 8'h75, 8'h00, 8'h01}, '{me, 8'h03, 8'h02, 8'h00, 8'h05}, 0);
	endtask : s_registers
	task s_exceptions;
		xact('{me, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, '{me, 8'h81, 8'h01}, 0);
		xact('{me, 8'h03, 8'h00, 8'h74, 8'h00, 8'h01}, '{me, 8'h83, 8'h02}, 0);
		xact('{me, 8'h04, 8'h00, 8'h0a, 8'h00, 8'h01}, '{me, 8'h84, 8'h02}, 0);
		xact('{me, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, '{me, 8'h82, 8'h03}, 0);
	endtask : s_exceptions
	task s_refused;
		int d;
		d = drops;
		xact('{me, 8'h03, 8'h00, 8'h73, 8'h00, 8'h01}, '{}, 1);
		chk(16'(drops), 16'(d + 1));
		xact('{8'h21, 8'h03, 8'h00, 8'h73, 8'h00, 8'h01}, '{}, 0);
		chk(16'(drops), 16'(d + 1));
		own_address <= 8'h00;
		xact('{8'h00, 8'h03, 8'h00, 8'h73, 8'h00, 8'h01}, '{}, 0);
		own_address <= me;
	endtask : s_refused
	task s_stall;
		slow <= 1'b1;
		xact('{me, 8'h02, 8'h00, 8'h00, 8'h00, 8'h15}, '{me, 8'h02, 8'h03, 8'hc3, 8'ha5, 8'h15}, 0);
		slow <= 1'b0;
	endtask : s_stall
	task s_text;
		do_reset(1'b1);
		xact('{me, 8'h03, 8'h00, 8'h75, 8'h00, 8'h01}, '{me, 8'h03, 8'h02, 8'h00, 8'h05}, 0);
	endtask : s_text
	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		ascii_mode = 1'b0;
		slow = 1'b0;
		own_address = me;
		discrete_inputs = 21'h000000;
		temperature_value = 32'h4290999a;
		relay_source_select_bits = 6'h16;
		current_loop_a_source_select = 16'h0005;
		errors = 0;
		tests_run = 0;
		cycles = 0;
		drops = 0;
		do_reset(1'b0);
		s_discrete();
		s_registers();
		s_exceptions();
		s_refused();
		s_stall();
		s_text();
		close_out();
	end
endmodule : testbench
